// File: rtl/pmsc_pkg.sv
// Package with register map, field positions and reset values of the power management control block.
// Functional notes
// - Detect flag at bit 7 of register one reports events only while detect logic is enabled.
// - Writing one to detect acknowledge bit 6 clears detect flag; it reads zero.
// - Detect interrupt enable bit 5 requests an interrupt while detect flag is set.
// - Write-once reset enable bit 4 forces device reset on detect flag when enabled.
// - Stop-qualification bit 3 set disables detection during stop mode.
// - Write-once detect enable bit 2 turns detect logic on and gates other bits.
// - Bit 0 of register one drives the reference buffer enable.
// - Write-once bits accept only the first write after reset.
// - Regulator control bit 7 refuses to set while deep stop select is one.
// - Regulator control clears itself when wake-on-interrupt is set and an interrupt occurs.
// - Regulator status bit 6 reads one while regulator is in standby.
// - Wake-on-interrupt bit 5 makes regulator leave standby on any interrupt.
// - Deep stop recovered flag at bit 3 reads one after recovery from stop2.
// - Writing one to acknowledge bit 2 clears the stop2 recovery flag.
// - Write-once deep stop allow bit 1 locks partial power-down out when zero; it only drives deep_stop_allow and does not block deep stop select.
// - Deep stop select bit 0 picks stop3 or stop2, refuses to set while regulator control.
// - Warning flag bit 7 of register three holds a present or past warning.
// - Warning acknowledge bit 6 clears flag only if the warning is gone.
// - Warning interrupt enable bit 3 requests an interrupt while warning flag is set.
// - Warning flag sets on supply falling below trip, also right after reset.
package pmsc_pkg;
  localparam logic [11:0] ADDR_CTRL1 = 12'h000;
  localparam logic [11:0] ADDR_CTRL2 = 12'h004;
  localparam logic [11:0] ADDR_CTRL3 = 12'h008;
  localparam int B1_DET_FLAG = 7;
  localparam int B1_DET_ACK = 6;
  localparam int B1_DET_IRQ_EN = 5;
  localparam int B1_DET_RST_EN = 4;
  localparam int B1_DET_STOP_QUAL = 3;
  localparam int B1_DET_EN = 2;
  localparam int B1_REF_BUF_EN = 0;
  localparam int B2_REG_CTRL = 7;
  localparam int B2_REG_STATUS = 6;
  localparam int B2_WAKE_INT = 5;
  localparam int B2_DS_FLAG = 3;
  localparam int B2_DS_ACK = 2;
  localparam int B2_DS_ALLOW = 1;
  localparam int B2_DS_SEL = 0;
  localparam int B3_WARN_FLAG = 7;
  localparam int B3_WARN_ACK = 6;
  localparam int B3_WARN_IRQ_EN = 3;
  // Reset values: detect enabled with reset enabled, as a brown-out safe default.
  localparam logic RST_DET_EN = 1'b1;
  localparam logic RST_DET_RST_EN = 1'b1;
endpackage : pmsc_pkg

// File: rtl/power_mgmt_status_control.sv
// Power management status and control registers with APB slave access.
`timescale 1ns/10ps
`default_nettype none
module power_mgmt_status_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic undervolt_detect_in,
  input wire logic undervolt_warning_in,
  input wire logic stop_mode,
  input wire logic regulator_in_standby,
  input wire logic stop2_recovered,
  input wire logic interrupt_active,
  output logic undervolt_detect_irq,
  output logic undervolt_warning_irq,
  output logic undervolt_reset_req,
  output logic reference_buffer_en,
  output logic regulator_standby_ctrl,
  output logic deep_stop_allow,
  output logic deep_stop_select
);

  typedef struct packed {
    logic [1:0] det_s;
    logic [1:0] warn_s;
    logic [1:0] stby_s;
    logic [1:0] rec_s;
    logic [1:0] int_s;
    logic rec_d;
    logic once1;
    logic once2;
    logic det_flag;
    logic det_irq_en;
    logic det_rst_en;
    logic det_stop_qual;
    logic det_en;
    logic ref_buf_en;
    logic reg_ctrl;
    logic wake_int;
    logic ds_flag;
    logic ds_allow;
    logic ds_sel;
    logic warn_flag;
    logic warn_irq_en;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic det_irq;
    logic warn_irq;
    logic rst_req;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Address decode shared by read and write paths.
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      pmsc_pkg::ADDR_CTRL1: reg_sel = 2'h1;
      pmsc_pkg::ADDR_CTRL2: reg_sel = 2'h2;
      pmsc_pkg::ADDR_CTRL3: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  // Next-state logic: synchronisers, flags, register writes and APB answer.
  always_comb begin
    logic access;
    logic wr;
    logic [1:0] sel;
    logic [7:0] wd;
    logic det_active;
    access = 1'b0;
    wr = 1'b0;
    sel = 2'h0;
    wd = 8'h00;
    det_active = 1'b0;
    st_nxt = st_r;
    st_nxt.det_s = {st_r.det_s[0], undervolt_detect_in};
    st_nxt.warn_s = {st_r.warn_s[0], undervolt_warning_in};
    st_nxt.stby_s = {st_r.stby_s[0], regulator_in_standby};
    st_nxt.rec_s = {st_r.rec_s[0], stop2_recovered};
    st_nxt.int_s = {st_r.int_s[0], interrupt_active};
    st_nxt.rec_d = st_r.rec_s[1];
    // Registered answer: setup cycle, one access cycle with pready low, then an access cycle with pready high.
    access = psel && penable && !st_r.ready;
    sel = reg_sel(paddr);
    wr = access && pwrite && pstrb[0] && (sel != 2'h0);
    wd = pwdata[7:0];
    st_nxt.ready = access;
    st_nxt.err = access && (sel == 2'h0);
    // Register one writes.
    if (wr && sel == 2'h1) begin
      st_nxt.det_irq_en = wd[pmsc_pkg::B1_DET_IRQ_EN];
      st_nxt.det_stop_qual = wd[pmsc_pkg::B1_DET_STOP_QUAL];
      st_nxt.ref_buf_en = wd[pmsc_pkg::B1_REF_BUF_EN];
      if (!st_r.once1) begin
        st_nxt.once1 = 1'b1;
        st_nxt.det_rst_en = wd[pmsc_pkg::B1_DET_RST_EN];
        st_nxt.det_en = wd[pmsc_pkg::B1_DET_EN];
      end
      if (wd[pmsc_pkg::B1_DET_ACK]) begin
        st_nxt.det_flag = 1'b0;
      end
    end
    // Register two writes; select wins over regulator control in one write.
    if (wr && sel == 2'h2) begin
      st_nxt.wake_int = wd[pmsc_pkg::B2_WAKE_INT];
      if (!st_r.once2) begin
        st_nxt.once2 = 1'b1;
        st_nxt.ds_allow = wd[pmsc_pkg::B2_DS_ALLOW];
      end
      if (wd[pmsc_pkg::B2_DS_SEL] && !st_r.reg_ctrl) begin
        st_nxt.ds_sel = 1'b1;
      end else if (!wd[pmsc_pkg::B2_DS_SEL]) begin
        st_nxt.ds_sel = 1'b0;
      end
      if (wd[pmsc_pkg::B2_REG_CTRL] && !st_r.ds_sel && !wd[pmsc_pkg::B2_DS_SEL]) begin
        st_nxt.reg_ctrl = 1'b1;
      end else if (!wd[pmsc_pkg::B2_REG_CTRL]) begin
        st_nxt.reg_ctrl = 1'b0;
      end
      if (wd[pmsc_pkg::B2_DS_ACK]) begin
        st_nxt.ds_flag = 1'b0;
      end
    end
    // Register three writes.
    if (wr && sel == 2'h3) begin
      st_nxt.warn_irq_en = wd[pmsc_pkg::B3_WARN_IRQ_EN];
      if (wd[pmsc_pkg::B3_WARN_ACK] && !st_r.warn_s[1]) begin
        st_nxt.warn_flag = 1'b0;
      end
    end
    // Hardware events set their flags; a set in the clearing cycle wins.
    if (st_r.wake_int && st_r.int_s[1]) begin
      st_nxt.reg_ctrl = 1'b0;
    end
    det_active = st_r.det_en && !(stop_mode && st_r.det_stop_qual);
    if (det_active && st_r.det_s[1]) begin
      st_nxt.det_flag = 1'b1;
    end
    if (st_r.rec_s[1] && !st_r.rec_d) begin
      st_nxt.ds_flag = 1'b1;
    end
    if (st_r.warn_s[1]) begin
      st_nxt.warn_flag = 1'b1;
    end
    st_nxt.det_irq = st_r.det_flag && st_r.det_irq_en && st_r.det_en;
    st_nxt.warn_irq = st_r.warn_flag && st_r.warn_irq_en;
    st_nxt.rst_req = st_r.det_flag && st_r.det_rst_en && st_r.det_en;
    // Read data; acknowledge bits and reserved bit 1 read zero.
    st_nxt.rdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (sel)
        2'h1: begin
          st_nxt.rdata[pmsc_pkg::B1_DET_FLAG] = st_r.det_flag && st_r.det_en;
          st_nxt.rdata[pmsc_pkg::B1_DET_IRQ_EN] = st_r.det_irq_en;
          st_nxt.rdata[pmsc_pkg::B1_DET_RST_EN] = st_r.det_rst_en;
          st_nxt.rdata[pmsc_pkg::B1_DET_STOP_QUAL] = st_r.det_stop_qual;
          st_nxt.rdata[pmsc_pkg::B1_DET_EN] = st_r.det_en;
          st_nxt.rdata[pmsc_pkg::B1_REF_BUF_EN] = st_r.ref_buf_en;
        end
        2'h2: begin
          st_nxt.rdata[pmsc_pkg::B2_REG_CTRL] = st_r.reg_ctrl;
          st_nxt.rdata[pmsc_pkg::B2_REG_STATUS] = st_r.stby_s[1];
          st_nxt.rdata[pmsc_pkg::B2_WAKE_INT] = st_r.wake_int;
          st_nxt.rdata[pmsc_pkg::B2_DS_FLAG] = st_r.ds_flag;
          st_nxt.rdata[pmsc_pkg::B2_DS_ALLOW] = st_r.ds_allow;
          st_nxt.rdata[pmsc_pkg::B2_DS_SEL] = st_r.ds_sel;
        end
        2'h3: begin
          st_nxt.rdata[pmsc_pkg::B3_WARN_FLAG] = st_r.warn_flag;
          st_nxt.rdata[pmsc_pkg::B3_WARN_IRQ_EN] = st_r.warn_irq_en;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.det_en <= pmsc_pkg::RST_DET_EN;
      st_r.det_rst_en <= pmsc_pkg::RST_DET_RST_EN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops; deep stop select is driven without gating by deep stop allow.
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign undervolt_detect_irq = st_r.det_irq;
  assign undervolt_warning_irq = st_r.warn_irq;
  assign undervolt_reset_req = st_r.rst_req;
  assign reference_buffer_en = st_r.ref_buf_en;
  assign regulator_standby_ctrl = st_r.reg_ctrl;
  assign deep_stop_allow = st_r.ds_allow;
  assign deep_stop_select = st_r.ds_sel;

endmodule : power_mgmt_status_control
`default_nettype wire

// File: tb/pmsc_checker.sv
// Checker of port-level relations for the power management block.
`timescale 1ns/10ps
`default_nettype none
module pmsc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic undervolt_warning_irq,
  input wire logic reference_buffer_en,
  input wire logic regulator_standby_ctrl,
  input wire logic deep_stop_allow,
  input wire logic deep_stop_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed reads and writes of the first register, and every cycle of a write to the third.
  wire rd1 = pready && psel && !pwrite && paddr == pmsc_pkg::ADDR_CTRL1;
  wire wr1 = pready && psel && penable && pwrite && pstrb[0] && paddr == pmsc_pkg::ADDR_CTRL1;
  wire wr3 = psel && pwrite && paddr == pmsc_pkg::ADDR_CTRL3;
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held high");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_ack_zero: assert property (rd1 |-> !prdata[pmsc_pkg::B1_DET_ACK]) else $error("ack bit read one");
  chk_flag_gated: assert property (rd1 |-> !prdata[pmsc_pkg::B1_DET_FLAG] || prdata[pmsc_pkg::B1_DET_EN])
    else $error("flag while disabled");
  chk_buf_write: assert property (wr1 |=> reference_buffer_en == $past(pwdata[0]))
    else $error("buffer enable wrong");
  chk_no_both: assert property (!(regulator_standby_ctrl && deep_stop_select)) else $error("both modes set");
  chk_allow_kept: assert property (!$fell(deep_stop_allow)) else $error("lock bit changed");
  chk_warn_clear: assert property ($fell(undervolt_warning_irq) |-> $past(wr3) || $past(wr3, 2))
    else $error("warning irq fell alone");
endmodule : pmsc_checker
bind power_mgmt_status_control pmsc_checker pmsc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .undervolt_warning_irq, .reference_buffer_en,
  .regulator_standby_ctrl, .deep_stop_allow, .deep_stop_select);
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking APB bench for the power management block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'hB2EE06CC;
  logic [3:0] pstrb = 4'hF;
  logic det = 0, warn = 0, stop_m = 0, stby = 0, s2 = 0, irq_a = 0;
  logic det_irq, warn_irq, rst_req, buf_en, reg_ctrl, ds_allow, ds_sel;
  logic [32:0] q[$];
  int error_cnt = 0, comparisons = 0;
  power_mgmt_status_control power_mgmt_status_control_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .undervolt_detect_in(det), .undervolt_warning_in(warn),
    .stop_mode(stop_m), .regulator_in_standby(stby), .stop2_recovered(s2), .interrupt_active(irq_a),
    .undervolt_detect_irq(det_irq), .undervolt_warning_irq(warn_irq), .undervolt_reset_req(rst_req),
    .reference_buffer_en(buf_en), .regulator_standby_ctrl(reg_ctrl), .deep_stop_allow(ds_allow),
    .deep_stop_select(ds_sel));
  always #2.5 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic bad(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask : cy
  // One APB transfer; a read notes d as its expected byte, index 3 is unmapped.
  task automatic xf(input logic w, input logic [1:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    seed = xs(seed);
    q.push_back({i == 2'd3, w ? 32'h0 : {24'h0, d}});
    psel <= 1;
    pwrite <= w;
    paddr <= i == 0 ? pmsc_pkg::ADDR_CTRL1 : i == 1 ? pmsc_pkg::ADDR_CTRL2 : i == 2 ? pmsc_pkg::ADDR_CTRL3 : 12'h00C;
    pwdata <= {seed[31:8], d};
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad("no ready");
      complete_run;
    end
    psel <= 0;
    penable <= 0;
  endtask : xf
  task automatic ck(input logic g, input logic x);
    @(negedge pclk);
    comparisons++;
    if (g !== x) bad("output level");
  endtask : ck
  // Takes the oldest expectation off the queue whenever an answer appears.
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      comparisons++;
      if ({pslverr, prdata} !== q.pop_front()) bad("read answer");
    end
  end
  // Main sequence: reset, then each register in turn, then a second reset.
  initial begin
    cy(6);
    presetn <= 1;
    xf(0, 0, 8'h14); xf(0, 1, 0); xf(0, 2, 0); xf(0, 3, 0);
    xf(1, 0, 8'h35); xf(0, 0, 8'h35); xf(1, 0, 8'h08); xf(0, 0, 8'h1C);
    xf(1, 0, 8'h20);
    det <= 1;
    cy(3);
    det <= 0;
    cy(4);
    xf(0, 0, 8'hB4); ck(det_irq, 1); ck(rst_req, 1);
    xf(1, 0, 8'h60); xf(0, 0, 8'h34); ck(det_irq, 0);
    stop_m <= 1;
    xf(1, 0, 8'h28);
    det <= 1;
    cy(3);
    det <= 0;
    cy(4);
    xf(0, 0, 8'h3C); ck(det_irq, 0);
    stop_m <= 0;
    $display("first register done");
    xf(1, 1, 8'h83); xf(0, 1, 8'h03); ck(ds_sel, 1);
    xf(1, 1, 8'h00); xf(0, 1, 8'h02); xf(1, 1, 8'hA0); xf(0, 1, 8'hA2); ck(reg_ctrl, 1);
    stby <= 1;
    cy(4);
    xf(0, 1, 8'hE2);
    irq_a <= 1;
    cy(4);
    irq_a <= 0;
    xf(0, 1, 8'h62); ck(reg_ctrl, 0);
    stby <= 0;
    s2 <= 1;
    cy(4);
    xf(0, 1, 8'h2A); xf(1, 1, 8'h24); xf(0, 1, 8'h22);
    $display("second register done");
    warn <= 1;
    cy(4);
    xf(0, 2, 8'h80); xf(1, 2, 8'h48); xf(0, 2, 8'h88); ck(warn_irq, 1);
    warn <= 0;
    cy(4);
    xf(0, 2, 8'h88); xf(1, 2, 8'h48); xf(0, 2, 8'h08); ck(warn_irq, 0);
    $display("third register done");
    warn <= 1;
    cy(2);
    presetn <= 0;
    cy(3);
    presetn <= 1;
    cy(4);
    pstrb <= 0;
    xf(1, 2, 8'h08);
    pstrb <= 4'hF;
    xf(0, 2, 8'h80); xf(0, 0, 8'h14); ck(ds_allow, 0); ck(buf_en, 0);
    $display("second reset done");
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
